// *** tcc_edge_det.sv ***
`timescale 1ns/1ps

module tcc_edge_det (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } tcc_edge_state_t;

  tcc_edge_state_t st_q;
  tcc_edge_state_t st_d;

  // A change counts only once the second and third stages agree.
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], pin_i};
    if (st_q.sync[2] == st_q.sync[1]) begin
      st_d.level = st_q.sync[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign rise_o = ce_i & (st_d.level & ~st_q.level);
  assign fall_o = ce_i & (~st_d.level & st_q.level);

endmodule

// *** tcc_pin_model.sv ***
`timescale 1ns/1ps

// Pins follow the commanded levels after a lag unrelated to the clock, as real wiring does.
module tcc_pin_model #(
  parameter int LAG_A_NS = 37,
  parameter int LAG_B_NS = 163
) (
  input  wire logic lvl_a_i,
  input  wire logic lvl_b_i,
  output logic      pin_a_o,
  output logic      pin_b_o
);
  initial pin_a_o = 1'b0;
  initial pin_b_o = 1'b0;
  always @(lvl_a_i) pin_a_o <= #(LAG_A_NS) lvl_a_i;
  always @(lvl_b_i) pin_b_o <= #(LAG_B_NS) lvl_b_i;
endmodule

// *** tcc_pkg.sv ***
package tcc_pkg;

  localparam int unsigned CNT_W = 16;

  // Register offsets, one register per address, data in the low bits.
  localparam logic [3:0] ADDR_MODE_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CAPCMP_CTRL = 4'h1;
  localparam logic [3:0] ADDR_EDGE_SEL    = 4'h2;
  localparam logic [3:0] ADDR_BIT_OP      = 4'h3;
  localparam logic [3:0] ADDR_COUNTER     = 4'h4;
  localparam logic [3:0] ADDR_CAPCMP_A    = 4'h5;
  localparam logic [3:0] ADDR_CAPCMP_B    = 4'h6;
  localparam logic [3:0] ADDR_EVENTS      = 4'h7;

  // Mode control register field positions.
  localparam int unsigned MC_OVF_BIT    = 0;
  localparam int unsigned MC_TOGGLE_BIT = 1;
  localparam int unsigned MC_RUN_LO_BIT = 2;
  localparam int unsigned MC_RUN_HI_BIT = 3;
  localparam logic [7:0]  MC_USED_MASK  = 8'h0f;
  localparam logic [7:0]  MODE_CTRL_RST = 8'h00;

  // Capture/compare control register field positions.
  localparam int unsigned CC_A_MODE_BIT = 0;
  localparam int unsigned CC_A_TRIG_BIT = 1;
  localparam int unsigned CC_B_MODE_BIT = 2;
  localparam logic [7:0]  CC_USED_MASK  = 8'h07;
  localparam logic [7:0]  CAPCMP_CTRL_RST = 8'h00;

  // Edge select register: bits 1:0 input a, bits 3:2 input b.
  localparam int unsigned ES_A_LO_BIT  = 0;
  localparam int unsigned ES_B_LO_BIT  = 2;
  localparam logic [7:0]  ES_USED_MASK = 8'h0f;
  localparam logic [7:0]  EDGE_SEL_RST = 8'h00;

  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CAPCMP_RST = 16'h0000;

  // Single bit operation word: bit 7 value, bits 6:4 register, bits 2:0 bit index.
  localparam int unsigned BITOP_VAL_BIT = 7;

  typedef enum logic [1:0] {
    TCC_RUN_STOP = 2'b00,
    TCC_RUN_FREE = 2'b01,
    TCC_RUN_EDGE = 2'b10,
    TCC_RUN_MATCH = 2'b11
  } tcc_run_t;

  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } tcc_bus_req_t;

  typedef struct packed {
    logic irq_a;
    logic irq_b;
  } tcc_irq_t;

endpackage

// *** tcc_timer_capcmp.sv ***
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - Register b in compare mode raises match_irq_b on a count tick where it equals the counter.
// - Register b in compare mode ignores capture triggers and keeps its value.
// - Register b in capture mode loads the counter on a valid input a edge.
// - Input a edge codes: 01 rising, 00 falling, 11 both; irq b each capture.
// - Trigger select 1: register a captures on opposite input a edge, none if 11.
// - Trigger select 0: register a captures on input b edges and raises irq a.
// - Reverse phase mode: input b edge raises irq a without capture; software masks.
// - Register b capture does not depend on the trigger select bit.
// - Compare value zero never matches at start; matches on counter 0000 to 0001.
// - Reset clears the mode control register, timer stopped.
// - Timer runs once the run field is non-zero and stops at 00.
// - Mode control accepts single bit and whole byte writes.
// - Run codes: 00 stop and clear, 01 free, 10 clear on edge, 11 on match.
// - Each register has a mode bit: 0 compare, 1 capture.
// - Overflow flag sets on FFFF to 0000 wrap; cleared by software or stop.
module tcc_timer_capcmp (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        count_en_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        timer_input_a_i,
  input  wire logic        timer_input_b_i,
  output logic             match_irq_a_o,
  output logic             match_irq_b_o,
  output logic             overflow_flag_o,
  output logic             running_o
);

  typedef struct packed {
    logic [7:0]  mode_ctrl;
    logic [7:0]  capcmp_ctrl;
    logic [7:0]  edge_sel;
    logic [15:0] main_counter;
    logic [15:0] capcmp_reg_a;
    logic [15:0] capcmp_reg_b;
    logic        armed;
    logic [15:0] rdata;
    tcc_pkg::tcc_irq_t irq;
    logic [1:0]  evt_sticky;
  } tcc_state_t;

  tcc_state_t st_q;
  tcc_state_t st_d;

  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  tcc_edge_det u_edge_a (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .pin_i  (timer_input_a_i),
    .rise_o (a_rise),
    .fall_o (a_fall)
  );

  tcc_edge_det u_edge_b (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .pin_i  (timer_input_b_i),
    .rise_o (b_rise),
    .fall_o (b_fall)
  );

  // Decodes a two-bit edge code against detected edges.
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      tcc_pkg::EDGE_RISE: hit = rise;
      tcc_pkg::EDGE_FALL: hit = fall;
      tcc_pkg::EDGE_BOTH: hit = rise | fall;
      default:            hit = 1'b0;
    endcase
    return hit;
  endfunction

  tcc_pkg::tcc_run_t run;
  logic [1:0] es_a;
  logic [1:0] es_b;
  logic       a_capture;
  logic       a_trig;
  logic       b_capture;
  logic       a_valid;
  logic       b_valid;
  logic       a_rev;
  logic       tick;
  logic       match_a;
  logic       match_b;
  logic [15:0] cnt_next;
  logic [7:0] bitop_mask;
  logic [7:0] mc_wr;

  always_comb begin
    run       = tcc_pkg::tcc_run_t'(st_q.mode_ctrl[tcc_pkg::MC_RUN_HI_BIT:
                                                   tcc_pkg::MC_RUN_LO_BIT]);
    es_a      = st_q.edge_sel[tcc_pkg::ES_A_LO_BIT +: 2];
    es_b      = st_q.edge_sel[tcc_pkg::ES_B_LO_BIT +: 2];
    a_capture = st_q.capcmp_ctrl[tcc_pkg::CC_A_MODE_BIT];
    a_trig    = st_q.capcmp_ctrl[tcc_pkg::CC_A_TRIG_BIT];
    b_capture = st_q.capcmp_ctrl[tcc_pkg::CC_B_MODE_BIT];
    a_valid   = edge_hit(es_a, a_rise, a_fall);
    b_valid   = edge_hit(es_b, b_rise, b_fall);
    // Reverse phase swaps the edge; both-edges code finds nothing to reverse.
    a_rev     = (es_a == tcc_pkg::EDGE_BOTH) ? 1'b0 :
                edge_hit(es_a, a_fall, a_rise);
    tick      = ce_i & count_en_i & (run != tcc_pkg::TCC_RUN_STOP);
    cnt_next  = st_q.main_counter + 16'h0001;
    // The armed bit holds back a zero compare value until the counter has left 0000.
    match_a   = tick & ~a_capture & (st_q.main_counter == st_q.capcmp_reg_a) &
                ((st_q.capcmp_reg_a != 16'h0000) | st_q.armed);
    match_b   = tick & ~b_capture & (st_q.main_counter == st_q.capcmp_reg_b) &
                ((st_q.capcmp_reg_b != 16'h0000) | st_q.armed);
    bitop_mask = 8'h01 << wdata_i[2:0];
    mc_wr     = wdata_i[7:0] & tcc_pkg::MC_USED_MASK;
  end

  always_comb begin
    st_d = st_q;
    st_d.irq = '0;
    st_d.rdata = 16'h0000;

    if (ce_i && rd_i) begin
      case (addr_i)
        tcc_pkg::ADDR_MODE_CTRL:   st_d.rdata = {8'h00, st_q.mode_ctrl};
        tcc_pkg::ADDR_CAPCMP_CTRL: st_d.rdata = {8'h00, st_q.capcmp_ctrl};
        tcc_pkg::ADDR_EDGE_SEL:    st_d.rdata = {8'h00, st_q.edge_sel};
        tcc_pkg::ADDR_COUNTER:     st_d.rdata = st_q.main_counter;
        tcc_pkg::ADDR_CAPCMP_A:    st_d.rdata = st_q.capcmp_reg_a;
        tcc_pkg::ADDR_CAPCMP_B:    st_d.rdata = st_q.capcmp_reg_b;
        tcc_pkg::ADDR_EVENTS:      st_d.rdata = {14'h0000, st_q.evt_sticky};
        default:                   st_d.rdata = 16'h0000;
      endcase
      // Reading the event word clears it; a new event below still wins.
      if (addr_i == tcc_pkg::ADDR_EVENTS) begin
        st_d.evt_sticky = 2'b00;
      end
    end

    // Counting, clear-and-start and overflow.
    if (tick) begin
      if (st_q.main_counter == tcc_pkg::CNT_MAX) begin
        st_d.mode_ctrl[tcc_pkg::MC_OVF_BIT] = 1'b1;
      end
      st_d.main_counter = cnt_next;
      if (st_q.main_counter == 16'h0000) begin
        st_d.armed = 1'b1;
      end
      if ((run == tcc_pkg::TCC_RUN_MATCH) && match_a) begin
        st_d.main_counter = tcc_pkg::CNT_RST;
      end
      if ((run == tcc_pkg::TCC_RUN_EDGE) && a_valid) begin
        st_d.main_counter = tcc_pkg::CNT_RST;
      end
    end

    if (match_a) begin
      st_d.irq.irq_a = 1'b1;
    end
    if (match_b) begin
      st_d.irq.irq_b = 1'b1;
    end

    // Captures take the count only while the timer runs; mode bit 0 blocks them.
    if (ce_i && (run != tcc_pkg::TCC_RUN_STOP)) begin
      if (b_capture && a_valid) begin
        st_d.capcmp_reg_b = st_q.main_counter;
        st_d.irq.irq_b = 1'b1;
      end
      if (a_capture && a_trig) begin
        if (a_rev) begin
          st_d.capcmp_reg_a = st_q.main_counter;
        end
        if (b_valid) begin
          st_d.irq.irq_a = 1'b1;
        end
      end else if (a_capture && b_valid) begin
        st_d.capcmp_reg_a = st_q.main_counter;
        st_d.irq.irq_a = 1'b1;
      end
    end

    // Register writes. Stores take effect after the hardware updates above.
    if (ce_i && wr_i) begin
      case (addr_i)
        tcc_pkg::ADDR_MODE_CTRL: begin
          st_d.mode_ctrl = mc_wr;
          if (st_q.mode_ctrl[tcc_pkg::MC_OVF_BIT] == 1'b0 && mc_wr[0] == 1'b0 &&
              st_d.mode_ctrl[tcc_pkg::MC_OVF_BIT] == 1'b0) begin
            st_d.mode_ctrl[tcc_pkg::MC_OVF_BIT] = 1'b0;
          end
          if (tick && st_q.main_counter == tcc_pkg::CNT_MAX) begin
            st_d.mode_ctrl[tcc_pkg::MC_OVF_BIT] = 1'b1;
          end
        end
        tcc_pkg::ADDR_CAPCMP_CTRL: st_d.capcmp_ctrl = wdata_i[7:0] & tcc_pkg::CC_USED_MASK;
        tcc_pkg::ADDR_EDGE_SEL:    st_d.edge_sel = wdata_i[7:0] & tcc_pkg::ES_USED_MASK;
        tcc_pkg::ADDR_BIT_OP: begin
          // Single-bit write to the mode control register (bits 6:4 equal zero).
          if (wdata_i[6:4] == 3'h0) begin
            if (wdata_i[tcc_pkg::BITOP_VAL_BIT]) begin
              st_d.mode_ctrl = (st_q.mode_ctrl | bitop_mask) & tcc_pkg::MC_USED_MASK;
            end else begin
              st_d.mode_ctrl = st_q.mode_ctrl & ~bitop_mask;
              if (tick && st_q.main_counter == tcc_pkg::CNT_MAX) begin
                st_d.mode_ctrl[tcc_pkg::MC_OVF_BIT] = 1'b1;
              end
            end
          end
        end
        tcc_pkg::ADDR_CAPCMP_A:    st_d.capcmp_reg_a = wdata_i;
        tcc_pkg::ADDR_CAPCMP_B:    st_d.capcmp_reg_b = wdata_i;
        default:                   st_d.rdata = st_d.rdata;
      endcase
    end

    if (st_d.irq.irq_a) begin
      st_d.evt_sticky[0] = 1'b1;
    end
    if (st_d.irq.irq_b) begin
      st_d.evt_sticky[1] = 1'b1;
    end

    // A stopped timer holds the counter and overflow flag at zero.
    if (st_d.mode_ctrl[tcc_pkg::MC_RUN_HI_BIT:tcc_pkg::MC_RUN_LO_BIT] == 2'b00) begin
      st_d.main_counter = tcc_pkg::CNT_RST;
      st_d.mode_ctrl[tcc_pkg::MC_OVF_BIT] = 1'b0;
      st_d.armed = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q.mode_ctrl    <= tcc_pkg::MODE_CTRL_RST;
      st_q.capcmp_ctrl  <= tcc_pkg::CAPCMP_CTRL_RST;
      st_q.edge_sel     <= tcc_pkg::EDGE_SEL_RST;
      st_q.main_counter <= tcc_pkg::CNT_RST;
      st_q.capcmp_reg_a <= tcc_pkg::CAPCMP_RST;
      st_q.capcmp_reg_b <= tcc_pkg::CAPCMP_RST;
      st_q.armed        <= 1'b0;
      st_q.rdata        <= 16'h0000;
      st_q.irq          <= '0;
      st_q.evt_sticky   <= 2'b00;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign rdata_o         = st_q.rdata;
  assign match_irq_a_o   = st_q.irq.irq_a;
  assign match_irq_b_o   = st_q.irq.irq_b;
  assign overflow_flag_o = st_q.mode_ctrl[tcc_pkg::MC_OVF_BIT];
  assign running_o       = st_q.mode_ctrl[tcc_pkg::MC_RUN_HI_BIT] |
                           st_q.mode_ctrl[tcc_pkg::MC_RUN_LO_BIT];

endmodule

// *** tcc_timer_capcmp_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end

module tcc_timer_capcmp_bench;
  logic        clk_i, nrst_i, ce_i, cnt_en, wr_i, rd_i, lvl_a, lvl_b;
  logic        pin_a, pin_b, irq_a, irq_b, ovf, run;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, v, c, r;
  logic [1:0]  codes [3];
  int          fails, n_compared, na, nb, a0, b0, k;

  tcc_pin_model u_pins (.lvl_a_i(lvl_a), .lvl_b_i(lvl_b), .pin_a_o(pin_a), .pin_b_o(pin_b));
  tcc_timer_capcmp uut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .count_en_i(cnt_en),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_input_a_i(pin_a), .timer_input_b_i(pin_b), .match_irq_a_o(irq_a),
    .match_irq_b_o(irq_b), .overflow_flag_o(ovf), .running_o(run));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (irq_a === 1'b1) na++;
    if (irq_b === 1'b1) nb++;
  end

  function automatic int n_edges(input logic [1:0] code);
    return (code == tcc_pkg::EDGE_BOTH) ? 2 : 1;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Stops the timer before the control registers change, since they must not move while running.
  task automatic cfg(input logic [15:0] cc, input logic [15:0] es);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0000);
    wr(tcc_pkg::ADDR_CAPCMP_CTRL, cc);
    wr(tcc_pkg::ADDR_EDGE_SEL, es);
  endtask

  // Levels are held well beyond the minimum capture pulse width.
  task automatic pin(input logic on_a, input logic lv);
    if (on_a)
      lvl_a <= lv;
    else
      lvl_b <= lv;
    repeat (14) @(posedge clk_i);
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    tally_and_finish;
  end

  initial begin
    {nrst_i, wr_i, rd_i, lvl_a, lvl_b, addr_i, wdata_i} = '0;
    {ce_i, cnt_en} = 2'b11;
    {fails, n_compared, na, nb} = '0;
    codes = '{tcc_pkg::EDGE_FALL, tcc_pkg::EDGE_RISE, tcc_pkg::EDGE_BOTH};
    void'($urandom(32'ha09ee41b));
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(tcc_pkg::ADDR_MODE_CTRL, v);
    `CHK(v, 16'h0000)
    `CHK(run, 1'b0)
    rd(4'h9, v);
    `CHK(v, 16'h0000)
    r = 16'h0020 + 16'($urandom_range(63));
    wr(tcc_pkg::ADDR_CAPCMP_B, r);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    for (k = 0; k < 400 && irq_b !== 1'b1; k++) @(posedge clk_i);
    rd(tcc_pkg::ADDR_COUNTER, v);
    `CHK(v - r < 16'h0008, 1'b1)
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0000);
    rd(tcc_pkg::ADDR_COUNTER, v);
    `CHK(v, 16'h0000)
    `CHK(run, 1'b0)
    r = 16'h0010 + 16'($urandom_range(15));
    wr(tcc_pkg::ADDR_CAPCMP_B, 16'h0000);
    wr(tcc_pkg::ADDR_CAPCMP_A, r);
    b0 = nb;
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h000c);
    repeat (r - 2) @(posedge clk_i);
    `CHK(nb - b0, 0)
    repeat (8) @(posedge clk_i);
    `CHK(nb - b0, 1)
    foreach (codes[i]) begin
      cfg(16'h0004 | (16'($urandom_range(1)) << 1), {14'h0, codes[i]});
      wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
      b0 = nb;
      pin(1'b1, 1'b1);
      pin(1'b1, 1'b0);
      `CHK(nb - b0, n_edges(codes[i]))
      rd(tcc_pkg::ADDR_CAPCMP_B, v);
      rd(tcc_pkg::ADDR_COUNTER, c);
      `CHK(v > 16'h0000 && v < c, 1'b1)
    end
    cfg(16'h0000, 16'h0003);
    r = 16'hf000 | 16'($urandom_range(4095));
    wr(tcc_pkg::ADDR_CAPCMP_B, r);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    b0 = nb;
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    rd(tcc_pkg::ADDR_CAPCMP_B, v);
    `CHK(v, r)
    `CHK(nb - b0, 0)
    cfg(16'h0003, 16'h0005);
    wr(tcc_pkg::ADDR_CAPCMP_A, 16'hffff);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    a0 = na;
    pin(1'b1, 1'b1);
    rd(tcc_pkg::ADDR_CAPCMP_A, v);
    `CHK(v, 16'hffff)
    pin(1'b1, 1'b0);
    rd(tcc_pkg::ADDR_CAPCMP_A, r);
    rd(tcc_pkg::ADDR_COUNTER, c);
    `CHK(r !== 16'hffff && r < c, 1'b1)
    `CHK(na - a0, 0)
    pin(1'b0, 1'b1);
    `CHK(na - a0, 1)
    rd(tcc_pkg::ADDR_CAPCMP_A, v);
    `CHK(v, r)
    cfg(16'h0003, 16'h0007);
    wr(tcc_pkg::ADDR_CAPCMP_A, 16'hffff);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    rd(tcc_pkg::ADDR_CAPCMP_A, v);
    `CHK(v, 16'hffff)
    k = $urandom_range(2);
    cfg(16'h0001, {12'h0, codes[k], 2'b00});
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    a0 = na;
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b1);
    `CHK(na - a0, n_edges(codes[k]))
    rd(tcc_pkg::ADDR_CAPCMP_A, v);
    rd(tcc_pkg::ADDR_COUNTER, c);
    `CHK(v !== 16'hffff && v < c, 1'b1)
    cfg(16'h0000, 16'h0001);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0008);
    repeat (40) @(posedge clk_i);
    pin(1'b1, 1'b1);
    rd(tcc_pkg::ADDR_COUNTER, c);
    `CHK(c < 16'h0014, 1'b1)
    // Count enable low must hold the counter; clock enable low must freeze everything.
    cfg(16'h0000, 16'h0000);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    repeat (5) @(posedge clk_i);
    cnt_en <= 1'b0;
    rd(tcc_pkg::ADDR_COUNTER, c);
    rd(tcc_pkg::ADDR_COUNTER, v);
    `CHK(v != 16'h0000 && v == c, 1'b1)
    cnt_en <= 1'b1;
    rd(tcc_pkg::ADDR_COUNTER, c);
    ce_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(tcc_pkg::ADDR_COUNTER, v);
    `CHK(v - c, 16'h0002)
    cfg(16'h0000, 16'h0000);
    wr(tcc_pkg::ADDR_MODE_CTRL, 16'h0004);
    for (k = 0; k < 70000 && ovf !== 1'b1; k++) @(posedge clk_i);
    `CHK(ovf, 1'b1)
    wr(tcc_pkg::ADDR_BIT_OP, 16'h0000);
    rd(tcc_pkg::ADDR_MODE_CTRL, v);
    `CHK(v, 16'h0004)
    wr(tcc_pkg::ADDR_BIT_OP, 16'h0002);
    rd(tcc_pkg::ADDR_MODE_CTRL, v);
    `CHK(v, 16'h0000)
    `CHK(run, 1'b0)
    tally_and_finish;
  end
endmodule

// *** tcc_timer_capcmp_checker.sv ***
`timescale 1ns/1ps

module tcc_timer_capcmp_checker (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic        count_en_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        timer_input_a_i,
  input wire logic        timer_input_b_i,
  input wire logic        match_irq_a_o,
  input wire logic        match_irq_b_o,
  input wire logic        overflow_flag_o,
  input wire logic        running_o
);
  // The capture modes are tracked here so an irq can be traced back to its pin.
  logic [1:0] cap_q;
  logic [3:0] age_a_q;
  logic [3:0] age_b_q;
  logic       pa_q;
  logic       pb_q;
  logic       wr_mc;

  assign wr_mc = wr_i && ce_i && addr_i == tcc_pkg::ADDR_MODE_CTRL;

  // The pin ages are set to F in reset so that no unknown survives until the first edge.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pa_q    <= 1'b0;
      pb_q    <= 1'b0;
      age_a_q <= 4'hf;
      age_b_q <= 4'hf;
    end else begin
      pa_q    <= timer_input_a_i;
      pb_q    <= timer_input_b_i;
      age_a_q <= (pa_q != timer_input_a_i) ? 4'h0 : age_a_q + {3'h0, age_a_q != 4'hf};
      age_b_q <= (pb_q != timer_input_b_i) ? 4'h0 : age_b_q + {3'h0, age_b_q != 4'hf};
    end
    if (!nrst_i) begin
      cap_q <= 2'h0;
    end else if (wr_i && ce_i && addr_i == tcc_pkg::ADDR_CAPCMP_CTRL) begin
      cap_q <= {wdata_i[tcc_pkg::CC_B_MODE_BIT], wdata_i[tcc_pkg::CC_A_MODE_BIT]};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i && ce_i |=>
    !running_o && !overflow_flag_o && !match_irq_a_o && !match_irq_b_o)
    else $error("outputs not quiet after reset");
  a_run_start: assert property (wr_mc && wdata_i[3:2] != 2'h0 |=> running_o)
    else $error("timer did not start");
  a_run_stop: assert property (wr_mc && wdata_i[3:2] == 2'h0 |=>
    !running_o && !overflow_flag_o)
    else $error("stop did not halt timer or clear overflow");
  a_idle_no_irq: assert property (!running_o [*3] |-> !match_irq_b_o)
    else $error("irq b while stopped");
  a_ovf_clear: assert property ($fell(overflow_flag_o) |->
    $past(wr_i && (addr_i == tcc_pkg::ADDR_MODE_CTRL || addr_i == tcc_pkg::ADDR_BIT_OP)))
    else $error("overflow cleared without a write");
  a_ovf_set: assert property ($rose(overflow_flag_o) |-> $past(running_o && count_en_i))
    else $error("overflow set while not counting");
  a_run_cause: assert property ($changed(running_o) |-> $past(wr_i))
    else $error("run state changed without a write");
  a_capb_cause: assert property (match_irq_b_o && cap_q[1] |->
    age_a_q inside {[4'h2:4'ha]})
    else $error("irq b in capture mode without a recent input a edge");
  a_capa_cause: assert property (match_irq_a_o && cap_q[0] |->
    age_b_q inside {[4'h2:4'ha]})
    else $error("irq a in capture mode without a recent input b edge");

  c_cap_b: cover property (match_irq_b_o && cap_q[1]);
  c_cap_a: cover property (match_irq_a_o && cap_q[0]);
  c_ovf: cover property ($rose(overflow_flag_o));
endmodule

bind tcc_timer_capcmp tcc_timer_capcmp_checker u_chk (
  .clk_i, .nrst_i, .ce_i, .count_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .timer_input_a_i, .timer_input_b_i, .match_irq_a_o, .match_irq_b_o,
  .overflow_flag_o, .running_o
);
